// ==== core/apd_decoder.sv ====
// Position and speed command decoder with status reply builder.
// Functional notes
// - A faulted motor takes no motion from the absolute position command.
// - Target angle is signed 32-bit, 0.01 degree per count, 36000 per turn.
// - Direction comes from sign of target minus present position.
// - Speed ceiling is unsigned 16-bit at one degree per second per count.
// - Zero acceleration selects direct PI tracking clamped to the speed ceiling.
// - In direct tracking a zero ceiling removes the clamp.
// - Nonzero acceleration selects a planned move, peak ceiling, ramp acceleration.
// - Every accepted position or speed command gets one reply echoing its code in byte 0; other codes get none.
// - Reply byte 1 is signed temperature, one degree Celsius per count.
// - Reply bytes 2-3 are signed torque current, 0.01 ampere per count.
// - Reply bytes 4-5 are signed shaft speed, one degree per second.
// - Reply bytes 6-7 are shaft angle in degrees, saturated to -32767 through 32767.
// - Speed command bytes 4-7 are signed target speed, 0.01 dps per count.
module apd_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request frame
  input wire logic req_valid,
  output logic req_ready,
  input wire apd_pkg::apd_frame_t req_frame,
  // Reply frame
  output logic rsp_valid,
  input wire logic rsp_ready,
  output apd_pkg::apd_frame_t rsp_frame,
  // Motor state
  input wire logic motor_fault,
  input wire logic [31:0] accel_cfg,
  input wire logic signed [31:0] present_pos,
  input wire apd_pkg::apd_status_t status,
  // Motion command to the loop controller
  output logic motion_valid,
  output apd_pkg::apd_motion_t motion,
  output logic cmd_rejected
);

  apd_pkg::apd_state_t s_r;
  apd_pkg::apd_state_t s_nxt;
  logic take;
  logic [7:0] code;
  logic is_pos;
  logic is_spd;
  logic [15:0] ceil_val;
  logic signed [31:0] val32;
  logic signed [15:0] angle_sat;
  logic dir_rev;
  logic dir_eq;

  // ==========================================================================
  // Request field extraction, little-endian.
  always_comb
  begin
    code = req_frame[apd_pkg::BYTE_CMD];
    ceil_val = {req_frame[apd_pkg::BYTE_CEIL_HI], req_frame[apd_pkg::BYTE_CEIL_LO]};
    val32 = {req_frame[apd_pkg::BYTE_VAL_3], req_frame[apd_pkg::BYTE_VAL_2],
      req_frame[apd_pkg::BYTE_VAL_1], req_frame[apd_pkg::BYTE_VAL_0]};
    is_pos = (code == apd_pkg::CMD_ABS_POS);
    is_spd = (code == apd_pkg::CMD_SPEED);
    take = req_valid && req_ready;
  end

  // ==========================================================================
  // Helpers.
  apd_sat16 u_sat (
    .din(status.shaft_angle),
    .dout(angle_sat)
  );

  apd_dir_sel u_dir (
    .target(val32),
    .present(present_pos),
    .reverse(dir_rev),
    .at_target(dir_eq)
  );

  // ==========================================================================
  // Next state.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.mot_vld = 1'b0;
    s_nxt.rejected = 1'b0;
    case (s_r.st)
      apd_pkg::ST_IDLE:
      begin
        if (take && (is_pos || is_spd))
        begin
          s_nxt.st = apd_pkg::ST_REPLY;
          s_nxt.rsp[apd_pkg::BYTE_CMD] = code;
          s_nxt.rsp[apd_pkg::BYTE_TEMP] = status.temperature;
          s_nxt.rsp[apd_pkg::BYTE_TORQ_LO] = status.torque_current[7:0];
          s_nxt.rsp[apd_pkg::BYTE_TORQ_HI] = status.torque_current[15:8];
          s_nxt.rsp[apd_pkg::BYTE_SPD_LO] = status.shaft_speed[7:0];
          s_nxt.rsp[apd_pkg::BYTE_SPD_HI] = status.shaft_speed[15:8];
          s_nxt.rsp[apd_pkg::BYTE_ANG_LO] = angle_sat[7:0];
          s_nxt.rsp[apd_pkg::BYTE_ANG_HI] = angle_sat[15:8];
          if (motor_fault)
          begin
            s_nxt.rejected = 1'b1;
          end
          else if (is_pos)
          begin
            s_nxt.mot_vld = 1'b1;
            s_nxt.mot.target_angle_value = val32;
            s_nxt.mot.speed_ceiling = ceil_val;
            s_nxt.mot.reverse = dir_rev;
            s_nxt.mot.at_target = dir_eq;
            s_nxt.mot.ramp_rate = accel_cfg;
            if (accel_cfg == apd_pkg::ACCEL_DIRECT)
            begin
              s_nxt.mot.mode = apd_pkg::MODE_DIRECT;
              s_nxt.mot.clamp_en = (ceil_val != apd_pkg::CEIL_UNCLAMPED);
            end
            else
            begin
              s_nxt.mot.mode = apd_pkg::MODE_PLANNED;
              s_nxt.mot.clamp_en = 1'b1;
            end
          end
          else
          begin
            s_nxt.mot_vld = 1'b1;
            s_nxt.mot.mode = apd_pkg::MODE_SPEED;
            s_nxt.mot.target_speed = val32;
            s_nxt.mot.reverse = val32[31];
            s_nxt.mot.clamp_en = 1'b0;
            s_nxt.mot.at_target = 1'b0;
          end
        end
      end
      apd_pkg::ST_REPLY:
      begin
        if (rsp_ready)
        begin
          s_nxt.st = apd_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = apd_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
      s_r.st <= apd_pkg::ST_IDLE;
      s_r.mot.mode <= apd_pkg::MODE_NONE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  always_comb
  begin
    req_ready = (s_r.st == apd_pkg::ST_IDLE);
    rsp_valid = (s_r.st == apd_pkg::ST_REPLY);
    rsp_frame = s_r.rsp;
    motion_valid = s_r.mot_vld;
    motion = s_r.mot;
    cmd_rejected = s_r.rejected;
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_fault_blocks;
    take && is_pos && motor_fault |=> !motion_valid && cmd_rejected;
  endproperty
  a_fault_blocks: assert property (p_fault_blocks) else $error("Faulted motor moved");

  property p_one_reply;
    take && (is_pos || is_spd) |=> rsp_valid && (rsp_frame[0] == $past(code));
  endproperty
  a_one_reply: assert property (p_one_reply) else $error("Reply missing or wrong code");

  property p_reply_holds;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_frame);
  endproperty
  a_reply_holds: assert property (p_reply_holds) else $error("Reply dropped early");

  property p_direction;
    take && is_pos && !motor_fault |=>
      motion.reverse == ($signed($past(val32)) < $signed($past(present_pos)));
  endproperty
  a_direction: assert property (p_direction) else $error("Wrong direction");

  property p_direct_mode;
    take && is_pos && !motor_fault && (accel_cfg == 32'h0000_0000) |=>
      motion.mode == apd_pkg::MODE_DIRECT && motion.clamp_en == (motion.speed_ceiling != 16'h0000);
  endproperty
  a_direct_mode: assert property (p_direct_mode) else $error("Direct mode wrong");

  property p_planned_mode;
    take && is_pos && !motor_fault && (accel_cfg != 32'h0000_0000) |=>
      motion.mode == apd_pkg::MODE_PLANNED && motion.ramp_rate == $past(accel_cfg);
  endproperty
  a_planned_mode: assert property (p_planned_mode) else $error("Planned mode wrong");

  property p_pos_fields;
    take && is_pos && !motor_fault |=> motion_valid
      && motion.target_angle_value == {$past(req_frame[7]), $past(req_frame[6]),
      $past(req_frame[5]), $past(req_frame[4])}
      && motion.speed_ceiling == {$past(req_frame[3]), $past(req_frame[2])};
  endproperty
  a_pos_fields: assert property (p_pos_fields) else $error("Position fields misread");

  property p_speed_fields;
    take && is_spd && !motor_fault |=> motion_valid && motion.mode == apd_pkg::MODE_SPEED
      && motion.target_speed == $past(val32) && motion.reverse == $past(val32[31]);
  endproperty
  a_speed_fields: assert property (p_speed_fields) else $error("Speed fields misread");

  property p_status_copy;
    take && (is_pos || is_spd) |=> rsp_frame[1] == $past(status.temperature)
      && {rsp_frame[3], rsp_frame[2]} == $past(status.torque_current)
      && {rsp_frame[5], rsp_frame[4]} == $past(status.shaft_speed);
  endproperty
  a_status_copy: assert property (p_status_copy) else $error("Status fields wrong");

  property p_motion_pulse;
    motion_valid |=> !motion_valid;
  endproperty
  a_motion_pulse: assert property (p_motion_pulse) else $error("Motion strobe too long");

  // ==========================================================================
  // Reply angle, refusal and hold checks.
  property p_sat_bound;
    angle_sat != 16'h8000;
  endproperty
  a_sat_bound: assert property (p_sat_bound) else $error("Angle outside symmetric range");

  property p_sat_pass;
    (status.shaft_angle <= apd_pkg::ANGLE_SAT_MAX)
      && (status.shaft_angle >= apd_pkg::ANGLE_SAT_MIN)
      |-> angle_sat == status.shaft_angle[15:0];
  endproperty
  a_sat_pass: assert property (p_sat_pass) else $error("In-range angle altered");

  property p_sat_clip;
    (status.shaft_angle > apd_pkg::ANGLE_SAT_MAX |-> angle_sat == 16'h7fff)
      and (status.shaft_angle < apd_pkg::ANGLE_SAT_MIN |-> angle_sat == 16'h8001);
  endproperty
  a_sat_clip: assert property (p_sat_clip) else $error("Out-of-range angle not clipped");

  property p_reply_angle;
    take && (is_pos || is_spd) |=> {rsp_frame[7], rsp_frame[6]} == $past(angle_sat);
  endproperty
  a_reply_angle: assert property (p_reply_angle) else $error("Reply angle wrong");

  property p_at_target;
    take && is_pos && !motor_fault |=>
      motion.at_target == ($past(val32) == $past(present_pos));
  endproperty
  a_at_target: assert property (p_at_target) else $error("Arrival flag wrong");

  property p_busy_refuses;
    rsp_valid |-> !req_ready;
  endproperty
  a_busy_refuses: assert property (p_busy_refuses) else $error("Request taken during reply");

  property p_reply_release;
    rsp_valid && rsp_ready |=> !rsp_valid && req_ready;
  endproperty
  a_reply_release: assert property (p_reply_release) else $error("Reply not released");

  property p_unknown_drop;
    take && !is_pos && !is_spd |=> !rsp_valid && !motion_valid && !cmd_rejected;
  endproperty
  a_unknown_drop: assert property (p_unknown_drop) else $error("Unknown code answered");

  property p_speed_fault;
    take && is_spd && motor_fault |=> !motion_valid && cmd_rejected;
  endproperty
  a_speed_fault: assert property (p_speed_fault) else $error("Faulted motor took speed");

  property p_reject_pulse;
    cmd_rejected |=> !cmd_rejected;
  endproperty
  a_reject_pulse: assert property (p_reject_pulse) else $error("Reject strobe too long");

  property p_motion_holds;
    !motion_valid |-> $stable(motion);
  endproperty
  a_motion_holds: assert property (p_motion_holds) else $error("Motion changed unasked");

  c_direct: cover property (motion_valid && motion.mode == apd_pkg::MODE_DIRECT);
  c_planned: cover property (motion_valid && motion.mode == apd_pkg::MODE_PLANNED);
  c_speed: cover property (motion_valid && motion.mode == apd_pkg::MODE_SPEED);
  c_fault: cover property (cmd_rejected ##1 rsp_valid && rsp_ready);
  c_stall: cover property (rsp_valid && !rsp_ready);

endmodule

// ==== core/apd_dir_sel.sv ====
// Direction selector from the sign of target minus present position.
module apd_dir_sel (
  // Positions
  input wire logic signed [31:0] target,
  input wire logic signed [31:0] present,
  // Result
  output logic reverse,
  output logic at_target
);

  logic signed [32:0] diff;

  // ==========================================================================
  // Difference is one bit wider so that it cannot wrap.
  always_comb
  begin
    diff = {target[31], target} - {present[31], present};
    reverse = diff[32];
    at_target = (diff == 33'h0_0000_0000);
  end

endmodule

// ==== core/apd_pkg.sv ====
// Package with constants and carrier types for the position command decoder.
package apd_pkg;

  // ==========================================================================
  // Command codes and request byte positions.
  localparam logic [7:0] CMD_ABS_POS = 8'ha4;
  localparam logic [7:0] CMD_SPEED = 8'ha2;
  localparam int BYTE_CMD = 0;
  localparam int BYTE_CEIL_LO = 2;
  localparam int BYTE_CEIL_HI = 3;
  localparam int BYTE_VAL_0 = 4;
  localparam int BYTE_VAL_1 = 5;
  localparam int BYTE_VAL_2 = 6;
  localparam int BYTE_VAL_3 = 7;

  // ==========================================================================
  // Reply byte positions.
  localparam int BYTE_TEMP = 1;
  localparam int BYTE_TORQ_LO = 2;
  localparam int BYTE_TORQ_HI = 3;
  localparam int BYTE_SPD_LO = 4;
  localparam int BYTE_SPD_HI = 5;
  localparam int BYTE_ANG_LO = 6;
  localparam int BYTE_ANG_HI = 7;

  // ==========================================================================
  // Scaling and limits.
  localparam int ANGLE_COUNTS_PER_TURN = 36000;
  localparam logic signed [31:0] ANGLE_SAT_MAX = 32'sh0000_7fff;
  localparam logic signed [31:0] ANGLE_SAT_MIN = -32'sh0000_7fff;
  localparam logic [15:0] CEIL_UNCLAMPED = 16'h0000;
  localparam logic [31:0] ACCEL_DIRECT = 32'h0000_0000;

  // ==========================================================================
  // Types.
  typedef logic [7:0][7:0] apd_frame_t;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_PLANNED = 2'b01,
    MODE_SPEED = 2'b10,
    MODE_NONE = 2'b11
  } apd_mode_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_REPLY = 1'b1
  } apd_fsm_t;

  typedef struct packed {
    logic signed [7:0] temperature;
    logic signed [15:0] torque_current;
    logic signed [15:0] shaft_speed;
    logic signed [31:0] shaft_angle;
  } apd_status_t;

  typedef struct packed {
    apd_mode_t mode;
    logic signed [31:0] target_angle_value;
    logic signed [31:0] target_speed;
    logic [15:0] speed_ceiling;
    logic clamp_en;
    logic [31:0] ramp_rate;
    logic reverse;
    logic at_target;
  } apd_motion_t;

  typedef struct packed {
    apd_fsm_t st;
    apd_frame_t rsp;
    apd_motion_t mot;
    logic mot_vld;
    logic rejected;
  } apd_state_t;

endpackage

// ==== core/apd_sat16.sv ====
// Signed 32-bit to signed 16-bit saturating narrower for the reply angle.
module apd_sat16 (
  // Data
  input wire logic signed [31:0] din,
  output logic signed [15:0] dout
);

  // ==========================================================================
  // Saturation.
  always_comb
  begin
    if (din > apd_pkg::ANGLE_SAT_MAX)
    begin
      dout = apd_pkg::ANGLE_SAT_MAX[15:0];
    end
    else if (din < apd_pkg::ANGLE_SAT_MIN)
    begin
      dout = apd_pkg::ANGLE_SAT_MIN[15:0];
    end
    else
    begin
      dout = din[15:0];
    end
  end

endmodule

// ==== verif/apd_decoder_test.sv ====
// Self-checking testbench for the position command decoder.
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module apd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, req_valid, req_ready, rsp_valid, rsp_ready;
  logic motion_valid, cmd_rejected, motor_fault;
  apd_pkg::apd_frame_t req_frame, rsp_frame, got;
  logic [31:0] accel_cfg;
  logic signed [31:0] present_pos;
  apd_pkg::apd_status_t status;
  apd_pkg::apd_motion_t motion, held;
  int num_errors, cmp_count, mv_cnt, rj_cnt;

  // ==========
  // Clock, pulse counters and instances.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    mv_cnt += int'(motion_valid === 1'b1);
    rj_cnt += int'(cmd_rejected === 1'b1);
  end

  apd_decoder dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_frame(req_frame), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_frame(rsp_frame), .motor_fault(motor_fault), .accel_cfg(accel_cfg),
    .present_pos(present_pos), .status(status), .motion_valid(motion_valid),
    .motion(motion), .cmd_rejected(cmd_rejected));

  apd_host_model host (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_frame(req_frame), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_frame(rsp_frame));

  // ==========
  // Shared tasks.
  task automatic results();
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic apd_pkg::apd_frame_t rep(input logic [7:0] c);
    logic [15:0] a;
    a = status.shaft_angle[15:0];
    if (status.shaft_angle > 32767)
      a = 16'h7fff;
    if (status.shaft_angle < -32767)
      a = 16'h8001;
    return {a, status.shaft_speed, status.torque_current, status.temperature, c};
  endfunction

  task automatic run(input apd_pkg::apd_frame_t f, input int stall, input bit want,
                     input logic [7:0] c, input int mv, input int rj);
    int m0, r0;
    bit ok;
    m0 = mv_cnt;
    r0 = rj_cnt;
    host.send(f, stall, want, got, ok);
    `CHK(ok, 1'b1)
    if (!ok)
      results();
    if (want)
      `CHK(got, rep(c))
    repeat (2) @(negedge clk);
    `CHK(mv_cnt - m0, mv)
    `CHK(rj_cnt - r0, rj)
    `CHK(req_ready, 1'b1)
  endtask

  task automatic mchk(input apd_pkg::apd_mode_t m, input logic signed [31:0] v,
                      input logic [15:0] cf, input logic cl, input logic rv);
    `CHK(motion.mode, m)
    if (m == apd_pkg::MODE_SPEED)
      `CHK(motion.target_speed, v)
    else
    begin
      `CHK(motion.target_angle_value, v)
      `CHK(motion.speed_ceiling, cf)
    end
    `CHK(motion.clamp_en, cl)
    `CHK(motion.reverse, rv)
    `CHK(motion.ramp_rate, accel_cfg)
  endtask

  // ==========
  // Scenarios.
  task automatic t_direct();
    @(negedge clk);
    status = {8'h32, 16'h0064, 16'h01f4, 32'sd45};
    run(host.mk(8'ha4, 8'h5a, 16'd500, 32'd36000), 0, 1, 8'ha4, 1, 0);
    mchk(apd_pkg::MODE_DIRECT, 36000, 16'd500, 1'b1, 1'b0);
    `CHK(motion.at_target, 1'b0)
  endtask

  task automatic t_planned();
    @(negedge clk);
    accel_cfg = 32'd1000;
    present_pos = 32'sd100;
    status = {8'hfb, 16'hff9c, 16'hfe0c, -32'sd40000};
    run(host.mk(8'ha4, 8'h00, 16'd500, -32'sd36000), 3, 1, 8'ha4, 1, 0);
    mchk(apd_pkg::MODE_PLANNED, -36000, 16'd500, 1'b1, 1'b1);
  endtask

  task automatic t_unclamp();
    @(negedge clk);
    accel_cfg = 32'd0;
    present_pos = 32'sd1234;
    status = {8'h19, 16'h0001, 16'h7fff, 32'sd40000};
    run(host.mk(8'ha4, 8'h00, 16'd0, 32'd1234), 1, 1, 8'ha4, 1, 0);
    mchk(apd_pkg::MODE_DIRECT, 1234, 16'd0, 1'b0, 1'b0);
    `CHK(motion.at_target, 1'b1)
  endtask

  task automatic t_speed();
    @(negedge clk);
    status = {8'h32, 16'hff9c, 16'hfe0c, -32'sd45};
    run(host.mk(8'ha2, 8'h00, 16'd0, 32'hffffd8f0), 2, 1, 8'ha2, 1, 0);
    mchk(apd_pkg::MODE_SPEED, -10000, 16'd0, 1'b0, 1'b1);
  endtask

  task automatic t_fault();
    @(negedge clk);
    held = motion;
    motor_fault = 1'b1;
    run(host.mk(8'ha4, 8'h00, 16'd500, 32'd777), 1, 1, 8'ha4, 0, 1);
    run(host.mk(8'ha2, 8'h00, 16'd0, 32'd300), 0, 1, 8'ha2, 0, 1);
    `CHK(motion, held)
    motor_fault = 1'b0;
  endtask

  task automatic t_unknown();
    run(host.mk(8'h30, 8'h00, 16'd1, 32'd5), 0, 0, 8'h30, 0, 0);
    `CHK(rsp_valid, 1'b0)
  endtask

  task automatic t_reset();
    bit ok;
    host.send(host.mk(8'ha4, 8'h00, 16'd9, 32'd5), 0, 0, got, ok);
    `CHK(ok, 1'b1)
    `CHK(rsp_valid, 1'b1)
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(rsp_valid, 1'b0)
    `CHK(req_ready, 1'b1)
    `CHK(motion.mode, apd_pkg::MODE_NONE)
    arst_n = 1'b1;
  endtask

  initial
  begin
    arst_n = 1'b0;
    motor_fault = 1'b0;
    accel_cfg = 32'd0;
    present_pos = 32'sd0;
    status = '0;
    repeat (4) @(negedge clk);
    `CHK(motion.mode, apd_pkg::MODE_NONE)
    `CHK(rsp_valid, 1'b0)
    `CHK(req_ready, 1'b1)
    arst_n = 1'b1;
    t_direct();
    t_planned();
    t_unclamp();
    t_speed();
    t_fault();
    t_unknown();
    t_reset();
    t_direct();
    results();
  end
endmodule

// ==== verif/apd_host_model.sv ====
// Host model that sends command frames to the decoder and takes its replies.
module apd_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request side
  output logic req_valid,
  input wire logic req_ready,
  output apd_pkg::apd_frame_t req_frame,
  // Reply side
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire apd_pkg::apd_frame_t rsp_frame
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // Frame builder and transfer task.
  initial
  begin
    req_valid = 1'b0;
    req_frame = '1;
    rsp_ready = 1'b0;
  end

  function automatic apd_pkg::apd_frame_t mk(input logic [7:0] c, input logic [7:0] b1,
                                             input logic [15:0] cf, input logic [31:0] v);
    return {v, cf, b1, c};
  endfunction

  task automatic send(input apd_pkg::apd_frame_t f, input int stall, input bit want,
                      output apd_pkg::apd_frame_t r, output bit ok);
    int n;
    r = '0;
    @(negedge clk);
    req_valid = 1'b1;
    req_frame = f;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 50);
    ok = (req_ready === 1'b1) && (arst_n === 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    req_frame = ~f;
    if (want && ok)
    begin
      repeat (stall) @(negedge clk);
      rsp_ready = 1'b1;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (rsp_valid !== 1'b1 && n < 50);
      r = rsp_frame;
      ok = (rsp_valid === 1'b1);
      @(negedge clk);
      rsp_ready = 1'b0;
    end
  endtask
endmodule
